// File: verilog/fcp_ctrl.sv
// Purpose: flash command sequencer, protocol checker and block protection.
// Assumes: array writes arrive as same-clock strobes from the bus decoder.
// Notes:   Avalon-MM slave with one wait state on every access.
`timescale 1ns/1ps
module fcp_ctrl
  import fcp_pkg::*;
#(
  parameter logic [14:0] PAGE_TICKS = T_PAGE,
  parameter logic [14:0] MASS_TICKS = T_MASS,
  parameter logic [15:0] FLASH_BASE = 16'h0000
)(
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [17:0]  avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  output logic [31:0]       avs_readdata,
  output logic              avs_waitrequest,
  input  wire logic         bus_debug,
  input  wire logic         secured,
  input  wire logic         stop_mode,
  input  wire logic         array_wr,
  input  wire logic [15:0]  array_addr,
  input  wire logic [7:0]   array_data,
  input  wire logic [7:0]   nv_protect_byte,
  input  wire logic [7:0]   nv_option_byte,
  input  wire logic [15:0]  vec_fetch_addr,
  output logic [15:0]       fetch_addr,
  output fcp_flash_req_type flash_req,
  output logic              hv_pump
);

  logic [31:0]       avs_readdata_ff;
  logic              avs_waitrequest_ff;
  logic [6:0]        div_ff;
  logic              div_ld_ff;
  logic              accerr_ff;
  logic              pviol_ff;
  logic              pend_ff;
  fcp_seq_type       seq_ff;
  logic [15:0]       lat_addr_ff;
  logic [7:0]        lat_data_ff;
  logic [7:0]        lat_cmd_ff;
  logic [7:0]        prot_ff;
  logic [7:0]        opt_ff;
  logic              load_ff;
  logic              busy_ff;
  logic [7:0]        cur_cmd_ff;
  logic [15:0]       cur_addr_ff;
  logic [CNT_W-1:0]  cnt_ff;
  logic              hv_pump_ff;
  fcp_flash_req_type flash_req_ff;
  logic [15:0]       fetch_addr_ff;

  logic        tick;
  logic        req;
  logic        take;
  logic        wr_take;
  logic [7:0]  wd;
  logic        a_div;
  logic        a_stat;
  logic        a_cmd;
  logic        a_prot;
  logic        a_opt;
  logic        a_ctrl;
  logic        cmd_valid;
  logic        dbg_lock;
  logic        arr_ok;
  logic        cmd_ok;
  logic        launch;
  logic        err_any;
  logic        prot_en;
  logic [15:0] last_unprot;
  logic        viol;
  logic        fin;
  logic        keep;
  logic        start;
  logic        start_run;
  logic        abort;
  logic [14:0] dur;
  logic        redir;
  logic [7:0]  rd_mux;

  assign avs_readdata    = avs_readdata_ff;
  assign avs_waitrequest = avs_waitrequest_ff;
  assign fetch_addr      = fetch_addr_ff;
  assign flash_req       = flash_req_ff;
  assign hv_pump         = hv_pump_ff;

  // flash timing tick, enabled once the divider is loaded
  fcp_clk_div u_div (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .enable  (div_ld_ff),
    .prdiv8  (div_ff[PRDIV8_BIT]),
    .div_val (div_ff[DIV_W-1:0]),
    .tick    (tick)
  );

  // bus decode; an access takes effect when waitrequest is sampled low
  assign req     = avs_read || avs_write;
  assign take    = req && !avs_waitrequest_ff;
  assign wr_take = take && avs_write;
  assign wd      = avs_writedata[7:0];
  assign a_div   = (avs_address == OFS_DIV);
  assign a_stat  = (avs_address == OFS_STAT);
  assign a_cmd   = (avs_address == OFS_CMD);
  assign a_prot  = (avs_address == OFS_PROT);
  assign a_opt   = (avs_address == OFS_OPT);
  assign a_ctrl  = a_div || a_stat || a_cmd || a_prot || a_opt;

  // command checks
  assign cmd_valid = (wd == CMD_BLANK) || (wd == CMD_PROG) ||
                     (wd == CMD_BURST) || (wd == CMD_PAGE) ||
                     (wd == CMD_MASS);
  assign dbg_lock  = bus_debug && secured &&
                     ((wd == CMD_PROG) || (wd == CMD_BURST) ||
                      (wd == CMD_PAGE));
  assign arr_ok    = array_wr && !accerr_ff && div_ld_ff && !pend_ff &&
                     (seq_ff == SEQ_EMPTY);
  assign cmd_ok    = wr_take && a_cmd && (seq_ff == SEQ_ADDR) &&
                     cmd_valid && !dbg_lock && !accerr_ff;
  assign launch    = wr_take && a_stat && wd[ST_CBEF] &&
                     (seq_ff == SEQ_CMD) && !accerr_ff;

  // any protocol violation in this cycle
  always_comb begin
    err_any = 1'b0;
    if (array_wr && !accerr_ff &&
        (!div_ld_ff || pend_ff || (seq_ff != SEQ_EMPTY))) begin
      err_any = 1'b1;
    end
    if (wr_take && a_cmd && (seq_ff == SEQ_ADDR) &&
        (!cmd_valid || dbg_lock)) begin
      err_any = 1'b1;
    end
    if (wr_take && a_cmd && (seq_ff == SEQ_CMD)) begin
      err_any = 1'b1;
    end
    if (wr_take && a_ctrl && !a_cmd && (seq_ff == SEQ_ADDR)) begin
      err_any = 1'b1;
    end
    if (take && a_ctrl && (seq_ff == SEQ_CMD) &&
        !(wr_take && a_stat && wd[ST_CBEF])) begin
      err_any = 1'b1;
    end
    if (abort) begin
      err_any = 1'b1;
    end
  end

  // protection boundary: upper bits from protect byte, ones below
  assign prot_en     = !prot_ff[PROT_DIS];
  assign last_unprot = {prot_ff[7:1], 9'h1FF};

  // page compare works on the address since the boundary is page aligned
  always_comb begin
    viol = 1'b0;
    if (prot_en) begin
      case (lat_cmd_ff)
        CMD_PROG, CMD_BURST, CMD_PAGE: viol = (lat_addr_ff > last_unprot);
        CMD_MASS:                      viol = 1'b1;
        default:                       viol = 1'b0;
      endcase
    end
  end

  // executor timing
  assign fin   = busy_ff && tick && (cnt_ff == 15'h0001);
  assign keep  = fin && pend_ff && (cur_cmd_ff == CMD_BURST) &&
                 (lat_cmd_ff == CMD_BURST) &&
                 (lat_addr_ff[15:ROW_BITS] == cur_addr_ff[15:ROW_BITS]);
  assign start = pend_ff && (!busy_ff || keep);
  assign start_run = start && !viol && !abort;
  assign abort = stop_mode && busy_ff && (cur_cmd_ff != CMD_BLANK);

  // duration of the command being started
  always_comb begin
    case (lat_cmd_ff)
      CMD_PROG:  dur = T_BYTE;
      CMD_BURST: dur = keep ? T_BURST : T_BYTE;
      CMD_PAGE:  dur = PAGE_TICKS;
      CMD_MASS:  dur = MASS_TICKS;
      default:   dur = T_BLANK;
    endcase
  end

  // one wait state per access; read data set up before the taking edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest_ff <= 1'b1;
      avs_readdata_ff    <= 32'h00000000;
    end else begin
      avs_waitrequest_ff <= !(req && avs_waitrequest_ff);
      if (avs_read && avs_waitrequest_ff) begin
        avs_readdata_ff <= {24'h000000, rd_mux};
      end
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_mux = 8'h00;
    if (a_div) begin
      rd_mux = {div_ld_ff, div_ff};
    end else if (a_stat) begin
      rd_mux = {!pend_ff, !pend_ff && !busy_ff, pviol_ff, accerr_ff, 4'h0};
    end else if (a_cmd) begin
      rd_mux = lat_cmd_ff;
    end else if (a_prot) begin
      rd_mux = prot_ff;
    end else if (a_opt) begin
      rd_mux = opt_ff;
    end else if (avs_address == {IDX_FLASH_PROTECT_NONVOLATILE, 2'b00}) begin
      rd_mux = nv_protect_byte;
    end else if (avs_address == {IDX_FLASH_OPTION_NONVOLATILE, 2'b00}) begin
      rd_mux = nv_option_byte;
    end
  end

  // divider register: written once, only with no error pending
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff    <= RST_DIV;
      div_ld_ff <= 1'b0;
    end else if (wr_take && a_div && !div_ld_ff && !accerr_ff && !err_any) begin
      div_ff    <= wd[6:0];
      div_ld_ff <= 1'b1;
    end
  end

  // access error: set wins over the write-one clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      accerr_ff <= 1'b0;
    end else if (err_any) begin
      accerr_ff <= 1'b1;
    end else if (wr_take && a_stat && wd[ST_ACCERR]) begin
      accerr_ff <= 1'b0;
    end
  end

  // protection violation flag, same clearing scheme
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pviol_ff <= 1'b0;
    end else if (start && viol) begin
      pviol_ff <= 1'b1;
    end else if (wr_take && a_stat && wd[ST_PVIOL]) begin
      pviol_ff <= 1'b0;
    end
  end

  // command sequence: array write, command write, launch
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_ff      <= SEQ_EMPTY;
      lat_addr_ff <= 16'h0000;
      lat_data_ff <= 8'h00;
      lat_cmd_ff  <= 8'h00;
    end else if (err_any) begin
      seq_ff <= SEQ_EMPTY;
    end else if (arr_ok) begin
      seq_ff      <= SEQ_ADDR;
      lat_addr_ff <= array_addr;
      lat_data_ff <= array_data;
    end else if (cmd_ok) begin
      seq_ff     <= SEQ_CMD;
      lat_cmd_ff <= wd;
    end else if (launch) begin
      seq_ff <= SEQ_EMPTY;
    end
  end

  // buffer-empty flag is the inverse of a launched, untaken command
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_ff <= 1'b0;
    end else if (launch && !err_any) begin
      pend_ff <= 1'b1;
    end else if (start) begin
      pend_ff <= 1'b0;
    end
  end

  // executor; a queued burst in the same row chains without a gap
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff     <= 1'b0;
      cur_cmd_ff  <= 8'h00;
      cur_addr_ff <= 16'h0000;
      cnt_ff      <= '0;
    end else if (abort) begin
      busy_ff <= 1'b0;
    end else if (start_run) begin
      busy_ff     <= 1'b1;
      cur_cmd_ff  <= lat_cmd_ff;
      cur_addr_ff <= lat_addr_ff;
      cnt_ff      <= dur;
    end else if (fin) begin
      busy_ff <= 1'b0;
    end else if (busy_ff && tick) begin
      cnt_ff <= cnt_ff - 15'h0001;
    end
  end

  // array drive and charge pump; blank check needs no high voltage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hv_pump_ff   <= 1'b0;
      flash_req_ff <= '{op: OP_NONE, addr: 16'h0000, data: 8'h00};
    end else if (start_run) begin
      hv_pump_ff        <= (lat_cmd_ff != CMD_BLANK);
      flash_req_ff.addr <= lat_addr_ff;
      flash_req_ff.data <= lat_data_ff;
      case (lat_cmd_ff)
        CMD_PROG, CMD_BURST: flash_req_ff.op <= OP_PROG;
        CMD_PAGE:            flash_req_ff.op <= OP_PAGE;
        CMD_MASS:            flash_req_ff.op <= OP_MASS;
        default:             flash_req_ff.op <= OP_BLANK;
      endcase
    end else if (abort || fin) begin
      hv_pump_ff      <= 1'b0;
      flash_req_ff.op <= OP_NONE;
    end
  end

  // working protection and option: load after reset; protection takes debug writes only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      load_ff <= 1'b1;
      prot_ff <= RST_PROT;
      opt_ff  <= RST_OPT;
    end else if (load_ff) begin
      load_ff <= 1'b0;
      prot_ff <= nv_protect_byte;
      opt_ff  <= nv_option_byte;
    end else if (wr_take && a_prot && bus_debug && !err_any) begin
      prot_ff <= wd;
    end
  end

  // vector redirect keeps the reset vector at its default place
  assign redir = !opt_ff[OPT_NORED] && prot_en && (last_unprot >= FLASH_BASE) &&
                 (vec_fetch_addr >= VEC_LO) && (vec_fetch_addr <= VEC_HI);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_addr_ff <= 16'h0000;
    end else if (redir) begin
      fetch_addr_ff <= {prot_ff[7:1], 3'h7, vec_fetch_addr[5:0]};
    end else begin
      fetch_addr_ff <= vec_fetch_addr;
    end
  end

endmodule

// File: verilog/fcp_pkg.sv
// Purpose: shared constants, types and register map of the flash command
//          sequencer with block protection.
// Assumes: 20 MHz bus clock; flash timing counted in divided clock ticks.
// Notes:   control registers sit one per aligned 32-bit word.
package fcp_pkg;

  // register byte addresses; nonvolatile copies as word indexes
  localparam logic [17:0] OFS_DIV    = 18'h00000;
  localparam logic [17:0] OFS_STAT   = 18'h00004;
  localparam logic [17:0] OFS_CMD    = 18'h00008;
  localparam logic [17:0] OFS_PROT   = 18'h0000C;
  localparam logic [17:0] OFS_OPT    = 18'h00010;
  localparam logic [15:0] IDX_FLASH_PROTECT_NONVOLATILE = 16'hFFBD;
  localparam logic [15:0] IDX_FLASH_OPTION_NONVOLATILE  = 16'hFFBF;

  // field positions
  localparam int DIV_LD_BIT  = 7;
  localparam int PRDIV8_BIT  = 6;
  localparam int DIV_W       = 6;
  localparam int ST_CBEF     = 7;
  localparam int ST_CCF      = 6;
  localparam int ST_PVIOL    = 5;
  localparam int ST_ACCERR   = 4;
  localparam int PROT_DIS    = 0;
  localparam int OPT_NORED   = 6;
  localparam int ROW_BITS    = 6;

  // reset values (protection disabled, redirect off until load)
  localparam logic [6:0] RST_DIV  = 7'h00;
  localparam logic [7:0] RST_PROT = 8'hFF;
  localparam logic [7:0] RST_OPT  = 8'hFF;

  // command codes
  localparam logic [7:0] CMD_BLANK = 8'h05;
  localparam logic [7:0] CMD_PROG  = 8'h20;
  localparam logic [7:0] CMD_BURST = 8'h25;
  localparam logic [7:0] CMD_PAGE  = 8'h40;
  localparam logic [7:0] CMD_MASS  = 8'h41;

  // vector window
  localparam logic [15:0] VEC_LO = 16'hFFC0;
  localparam logic [15:0] VEC_HI = 16'hFFFD;

  // durations in flash timing ticks
  localparam int         CNT_W       = 15;
  localparam logic [14:0] T_BYTE     = 15'h0009;
  localparam logic [14:0] T_BURST    = 15'h0004;
  localparam logic [14:0] T_PAGE     = 15'h0FA0;
  localparam logic [14:0] T_MASS     = 15'h4E20;
  localparam logic [14:0] T_BLANK    = 15'h0001;

  typedef enum logic [1:0] {
    SEQ_EMPTY = 2'b00,
    SEQ_ADDR  = 2'b01,
    SEQ_CMD   = 2'b11
  } fcp_seq_type;

  typedef enum logic [2:0] {
    OP_NONE  = 3'h0,
    OP_BLANK = 3'h1,
    OP_PROG  = 3'h2,
    OP_PAGE  = 3'h3,
    OP_MASS  = 3'h4
  } fcp_op_type;

  typedef struct packed {
    fcp_op_type  op;
    logic [15:0] addr;
    logic [7:0]  data;
  } fcp_flash_req_type;

endpackage

// File: verilog/fcp_clk_div.sv
// Purpose: flash timing tick from the bus clock.
// Assumes: divisor fixed once loaded.
// Notes:   tick rate = sys_clk / (prdiv8 ? 8 : 1) / (div_val + 1).
`timescale 1ns/1ps
module fcp_clk_div
  import fcp_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             enable,
  input  wire logic             prdiv8,
  input  wire logic [DIV_W-1:0] div_val,
  output logic                  tick
);

  logic [2:0]       pre_ff;
  logic [DIV_W-1:0] cnt_ff;
  logic             tick_ff;
  logic             pre_tick;

  assign pre_tick = !prdiv8 || (pre_ff == 3'h7);
  assign tick     = tick_ff;

  // prescaler, free running once enabled
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff <= 3'h0;
    end else if (enable) begin
      pre_ff <= pre_ff + 3'h1;
    end
  end

  // main divider; tick is a single-cycle enable
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= 1'b0;
      if (enable && pre_tick) begin
        if (cnt_ff == div_val) begin
          cnt_ff  <= '0;
          tick_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 1'b1;
        end
      end
    end
  end

endmodule

// File: dv/fcp_ctrl_sva.sv
// Purpose: port-level checks of the flash command sequencer.
// Assumes: divider tick no faster than every sys_clk; one clock domain.
// Notes:   bound into fcp_ctrl; sees its ports only.
`timescale 1ns/1ps
module fcp_ctrl_sva
  import fcp_pkg::*;
#(
  parameter logic [14:0] PAGE_TICKS = T_PAGE
)(
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic              stop_mode,
  input wire logic [15:0]       vec_fetch_addr,
  input wire logic [15:0]       fetch_addr,
  input wire fcp_flash_req_type flash_req,
  input wire logic              hv_pump
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // cycles spent in page erase, zeroed between operations
  logic [15:0] page_cnt_ff;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      page_cnt_ff <= 16'h0000;
    end else if (flash_req.op == OP_PAGE) begin
      page_cnt_ff <= page_cnt_ff + 16'h0001;
    end else begin
      page_cnt_ff <= 16'h0000;
    end
  end

  sequence s_prog_hold;
    (flash_req.op == OP_PROG) [*8];
  endsequence
  sequence s_stop_hit;
    hv_pump && stop_mode;
  endsequence

  property p_prog_len;
    $rose(flash_req.op == OP_PROG) |-> s_prog_hold;
  endproperty
  a_prog_len: assert property (p_prog_len) else $error("program ended too soon");
  property p_page_len;
    $fell(flash_req.op == OP_PAGE) |-> page_cnt_ff >= ({1'b0, PAGE_TICKS} - 16'h0002);
  endproperty
  a_page_len: assert property (p_page_len) else $error("page erase ended too soon");
  property p_stop_abort;
    s_stop_hit |-> ##[1:4] (!hv_pump && flash_req.op == OP_NONE);
  endproperty
  a_stop_abort: assert property (p_stop_abort) else $error("stop did not abort");
  property p_pump_off;
    !(flash_req.op inside {OP_PROG, OP_PAGE, OP_MASS}) |-> !hv_pump;
  endproperty
  a_pump_off: assert property (p_pump_off) else $error("pump on without program or erase");
  property p_burst_row;
    (hv_pump && $past(hv_pump) && $changed(flash_req.addr)) |-> flash_req.addr[5:0] != 6'h00;
  endproperty
  a_burst_row: assert property (p_burst_row) else $error("pump held across a row start");
  property p_fetch_rst;
    vec_fetch_addr >= 16'hFFFE |=> fetch_addr == $past(vec_fetch_addr);
  endproperty
  a_fetch_rst: assert property (p_fetch_rst) else $error("reset vector moved");
  property p_fetch_low;
    vec_fetch_addr < VEC_LO |=> fetch_addr == $past(vec_fetch_addr);
  endproperty
  a_fetch_low: assert property (p_fetch_low) else $error("non-vector fetch moved");
  property p_fetch_ofs;
    (vec_fetch_addr >= VEC_LO && vec_fetch_addr <= VEC_HI) |=> fetch_addr[5:0] == $past(vec_fetch_addr[5:0]);
  endproperty
  a_fetch_ofs: assert property (p_fetch_ofs) else $error("vector offset changed");
endmodule

bind fcp_ctrl fcp_ctrl_sva #(.PAGE_TICKS(PAGE_TICKS)) fcp_ctrl_sva_i (
  .sys_clk        (sys_clk),
  .rst_n          (rst_n),
  .stop_mode      (stop_mode),
  .vec_fetch_addr (vec_fetch_addr),
  .fetch_addr     (fetch_addr),
  .flash_req      (flash_req),
  .hv_pump        (hv_pump)
);

// File: dv/fcp_host_model.sv
// Purpose: cpu-side bus master and array writer for the sequencer.
// Assumes: Avalon-MM slave that answers by dropping waitrequest.
// Notes:   released lines show inverted values so stale data never passes.
`timescale 1ns/1ps
module fcp_host_model (
  input  wire logic        sys_clk,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  output logic [17:0]      avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  output logic             array_wr,
  output logic [15:0]      array_addr,
  output logic [7:0]       array_data
);
  // idle bus at time zero
  initial begin
    {avs_read, avs_write, array_wr} = 3'h0;
    avs_address = 18'h00000;
    avs_writedata = 32'h00000000;
    {array_addr, array_data} = 24'h000000;
  end

  // one access, held until waitrequest is seen low; commands and launches go through here
  task automatic acc(input logic w, input logic [17:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= w;
    avs_read <= ~w;
    // waitrequest is read at each rising edge before the slave updates it; only the watchdog ends a stuck wait
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    {avs_write, avs_read} <= 2'h0;
    avs_address <= ~a;
    avs_writedata <= ~{24'h000000, d};
  endtask

  // single-cycle array write strobe
  task automatic arr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    array_wr <= 1'b1;
    {array_addr, array_data} <= {a, d};
    @(posedge sys_clk);
    array_wr <= 1'b0;
    {array_addr, array_data} <= ~{a, d};
  endtask
endmodule

// File: dv/fcp_ctrl_bench.sv
// Purpose: self-checking bench of the flash command sequencer.
// Assumes: divider 1, prescaler on after the second reset; short erase counts.
// Notes:   every command goes through the host model's bus tasks.
`timescale 1ns/1ps
module fcp_ctrl_bench
  import fcp_pkg::*;
;
  logic              sys_clk, rst_n, bus_debug, secured, stop_mode;
  logic [7:0]        nvp, nvo, q;
  logic [15:0]       vec;
  logic [17:0]       avs_address;
  logic              avs_read, avs_write, avs_waitrequest, array_wr, hv_pump;
  logic [31:0]       avs_writedata, avs_readdata;
  logic [15:0]       array_addr, fetch_addr;
  logic [7:0]        array_data;
  fcp_flash_req_type flash_req;
  int                err_total, n_tests, falls, cyc;
  typedef struct packed {
    logic [7:0]  code;
    logic [15:0] addr;
    fcp_op_type  op;
    logic [7:0]  flags;
  } fcp_row_type;
  // plain commands, then three invalid codes; erase rows use unaligned addresses inside the page
  localparam fcp_row_type ROWS [8] = '{'{8'h05, 16'h2000, OP_BLANK, 8'h00}, '{8'h20, 16'h2203, OP_PROG, 8'h00},
    '{8'h25, 16'h2404, OP_PROG, 8'h00}, '{8'h40, 16'h27FF, OP_PAGE, 8'h00}, '{8'h41, 16'h5123, OP_MASS, 8'h00},
    '{8'h42, 16'h2000, OP_NONE, 8'h10}, '{8'h00, 16'h2000, OP_NONE, 8'h10}, '{8'h21, 16'h2000, OP_NONE, 8'h10}};

  fcp_ctrl #(.PAGE_TICKS(15'h0014), .MASS_TICKS(15'h0028)) fcp_ctrl_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bus_debug(bus_debug), .secured(secured),
    .stop_mode(stop_mode), .array_wr(array_wr), .array_addr(array_addr), .array_data(array_data),
    .nv_protect_byte(nvp), .nv_option_byte(nvo), .vec_fetch_addr(vec), .fetch_addr(fetch_addr),
    .flash_req(flash_req), .hv_pump(hv_pump));
  fcp_host_model fcp_host_model_i (.sys_clk(sys_clk), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .array_wr(array_wr), .array_addr(array_addr), .array_data(array_data));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // pump drops and program cycles, for burst timing
  always @(negedge hv_pump) falls++;
  always @(posedge sys_clk) if (flash_req.op == OP_PROG) cyc++;

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [17:0] a);
    fcp_host_model_i.acc(1'b0, a, 8'h00, q);
  endtask
  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    fcp_host_model_i.acc(1'b1, a, d, dummy);
  endtask
  // array write, command, and launch when asked
  task automatic seq(input logic [15:0] a, input logic [7:0] code, input logic go);
    fcp_host_model_i.arr(a, 8'h5A);
    wr(OFS_CMD, code);
    if (go) wr(OFS_STAT, 8'h80);
  endtask
  task automatic wait_op(input fcp_op_type op);
    for (int n = 0; n < 40 && flash_req.op !== op; n++) @(negedge sys_clk);
  endtask
  // if no error is expected poll command complete, then check and clear the error flags
  task automatic finish(input logic [7:0] flags);
    int n;
    n = 0;
    if (flags == 8'h00) begin
      rd(OFS_STAT);
      while (q[ST_CCF] !== 1'b1 && n < 400) begin
        rd(OFS_STAT);
        n++;
      end
      chk8("status_done", 8'hC0, q & 8'hC0);
    end
    rd(OFS_STAT);
    chk8("status_err", flags, q & 8'h30);
    wr(OFS_STAT, 8'h30);
    rd(OFS_STAT);
    chk8("status_clear", 8'h00, q & 8'h30);
  endtask
  task automatic complete_run();
    if (err_total == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // watchdog well past the expected run of under a thousand cycles
  initial begin
    #(50 * 40000);
    err_total++;
    complete_run();
  end

  initial begin
    {rst_n, bus_debug, secured, stop_mode} = 4'h0;
    {err_total, n_tests, falls, cyc} = 128'h0;
    {nvp, nvo, vec} = {8'hFF, 8'hFF, 16'h0000};
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rd(OFS_DIV);
    chk8("div_reset", 8'h00, q);
    rd(OFS_STAT);
    chk8("status_reset", 8'hC0, q);
    rd(OFS_PROT);
    chk8("prot_reset", 8'hFF, q);
    rd(18'h00020);
    chk8("unmapped", 8'h00, q);
    fcp_host_model_i.arr(16'h2000, 8'h11);
    finish(8'h10);
    wr(OFS_DIV, 8'h01);
    rd(OFS_DIV);
    chk8("div_loaded", 8'h81, q);
    for (int i = 0; i < 8; i++) begin
      seq(ROWS[i].addr, ROWS[i].code, ROWS[i].flags == 8'h00);
      if (ROWS[i].op != OP_NONE) begin
        wait_op(ROWS[i].op);
        chk16("req_addr", ROWS[i].addr, flash_req.addr);
        chk8("req_op", {5'h00, ROWS[i].op}, {5'h00, flash_req.op});
        if (ROWS[i].op == OP_PROG) chk8("req_data", 8'h5A, flash_req.data);
      end
      finish(ROWS[i].flags);
    end
    fcp_host_model_i.arr(16'h3000, 8'h22);
    wr(OFS_STAT, 8'h00);
    finish(8'h10);
    fcp_host_model_i.arr(16'h3000, 8'h22);
    fcp_host_model_i.arr(16'h3001, 8'h22);
    finish(8'h10);
    seq(16'h3000, CMD_PROG, 1'b0);
    wr(OFS_CMD, CMD_PROG);
    finish(8'h10);
    fcp_host_model_i.arr(16'h3000, 8'h22);
    wr(OFS_PROT, 8'hFF);
    finish(8'h10);
    seq(16'h3000, CMD_PROG, 1'b0);
    rd(OFS_DIV);
    finish(8'h10);
    {secured, bus_debug} <= 2'h3;
    seq(16'h3000, CMD_PROG, 1'b0);
    finish(8'h10);
    seq(16'h3000, CMD_MASS, 1'b1);
    finish(8'h00);
    {secured, bus_debug} <= 2'h0;
    seq(16'h4000, CMD_MASS, 1'b1);
    wait_op(OP_MASS);
    @(posedge sys_clk);
    stop_mode <= 1'b1;
    repeat (3) @(posedge sys_clk);
    stop_mode <= 1'b0;
    finish(8'h10);
    // same-row pair keeps the pump, a row crossing cycles it
    for (int j = 0; j < 2; j++) begin
      {falls, cyc} = 64'h0;
      seq(j ? 16'h603F : 16'h6000, CMD_BURST, 1'b1);
      seq(j ? 16'h6040 : 16'h6001, CMD_BURST, 1'b1);
      finish(8'h00);
      chk8("pump_drops", 8'(j + 1), 8'(falls));
      chk8("burst_time", 8'(j), {7'h00, cyc >= 32});
    end
    {nvp, nvo} <= {8'hDE, 8'hBF};
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    wr(OFS_DIV, 8'h41);
    rd(OFS_DIV);
    chk8("div_prescale", 8'hC1, q);
    seq(16'hE000, CMD_PROG, 1'b1);
    finish(8'h20);
    seq(16'hDFFF, CMD_PROG, 1'b1);
    finish(8'h00);
    rd(OFS_PROT);
    chk8("prot_load", 8'hDE, q);
    rd(18'h3FEF4);
    chk8("nv_prot", 8'hDE, q);
    rd(18'h3FEFC);
    chk8("nv_opt", 8'hBF, q);
    vec <= 16'hFFE0;
    repeat (3) @(posedge sys_clk);
    chk16("fetch_vec", 16'hDFE0, fetch_addr);
    vec <= 16'hFFFE;
    repeat (3) @(posedge sys_clk);
    chk16("fetch_reset", 16'hFFFE, fetch_addr);
    wr(OFS_PROT, 8'hFF);
    rd(OFS_PROT);
    chk8("prot_app_wr", 8'hDE, q);
    bus_debug <= 1'b1;
    wr(OFS_PROT, 8'hFF);
    rd(OFS_PROT);
    chk8("prot_dbg_wr", 8'hFF, q);
    vec <= 16'hFFE0;
    repeat (3) @(posedge sys_clk);
    chk16("fetch_plain", 16'hFFE0, fetch_addr);
    complete_run();
  end
endmodule
